// ==== srpcs_fifo.sv ====
// Transmit word queue with registered read data
`timescale 1ns/1ps
module srpcs_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // Fill and drain sides
  srpcs_stream_if.snk    wr,
  srpcs_stream_if.src    rd
);
  import srpcs_pkg::*;
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q, cnt_d;
  logic          ready_q, ov_q;
  logic [W-1:0]  dout_q;
  wire           push = wr.valid && ready_q;
  wire           pop  = (cnt_q != '0) && (!ov_q || rd.ready);

  // Occupancy and registered fill-side ready
  assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign wr.ready = ready_q;
  assign rd.data  = dout_q;
  assign rd.valid = ov_q;

  // Pointers and fill state
  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      wp_q    <= wp_q + AW'(push);
      rp_q    <= rp_q + AW'(pop);
      cnt_q   <= cnt_d;
      ready_q <= cnt_d < (AW+1)'(DEPTH);
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  // Output register stage
  always_ff @(posedge clk) begin
    if (reset) begin
      ov_q   <= 1'b0;
      dout_q <= '0;
    end else if (pop) begin
      ov_q   <= 1'b1;
      dout_q <= mem[rp_q];
    end else if (rd.ready) begin
      ov_q   <= 1'b0;
    end
  end
endmodule // srpcs_fifo

// ==== srpcs_lane.sv ====
// Single-lane coding sublayer: code, align, lane sync, byte serdes, skip match
// Operation
// - Sync asserts only after 127 commas with no invalid group between them; valid non-comma groups do not reset the count.
// - Comma recognised in both disparity forms, 0101111100 and 1010000011.
// - Sync drops on three errors within 255 good groups, or on reset.
// - Aligner hunts automatically for the ten-bit comma while out of sync.
// - Transmit encodes 8b/10b, receive decodes 8b/10b and aligns the stream.
// - One lane only, line rate 1.25, 2.5 or 3.125 Gbps.
// - Byte serializer and deserializer always used, two bytes per fabric word.
// - Fabric clock is 62.5, 125 or 156.25 MHz for those rates.
// - At most one skip inserted or deleted per comma-skip sequence.
`timescale 1ns/1ps
module srpcs_lane #(
  parameter int LINE_MBPS  = 3125,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // Fabric transmit words
  input  wire logic [srpcs_pkg::WORD_W-1:0]  tx_word,
  input  wire logic [srpcs_pkg::CTRL_W-1:0]  tx_ctrl,
  input  wire logic                          tx_valid,
  output wire logic                          tx_ready,
  // Serializer side code groups
  output logic      [srpcs_pkg::CG_W-1:0]    tx_code,
  input  wire logic [srpcs_pkg::CG_W-1:0]    rx_raw,
  // Fabric receive words
  output logic      [srpcs_pkg::WORD_W-1:0]  rx_word,
  output logic      [srpcs_pkg::CTRL_W-1:0]  rx_ctrl,
  output logic      [srpcs_pkg::CTRL_W-1:0]  rx_err,
  output logic                               rx_valid,
  output logic                               rx_sync,
  // Clock compensation requests and answers
  input  wire logic                          rm_ins_req,
  input  wire logic                          rm_del_req,
  output logic                               rm_ins_done,
  output logic                               rm_del_done
);
  import srpcs_pkg::*;

  // ----------------------------------------------------------------------
  // Rate checks
  // ----------------------------------------------------------------------
  localparam int FABRIC_KHZ = LINE_MBPS * 1000 / BITS_PER_WORD;
  if (LINE_MBPS != RATE_LOW_MBPS && LINE_MBPS != RATE_MID_MBPS &&
      LINE_MBPS != RATE_HIGH_MBPS) begin : g_bad_rate
    $error("line rate must be 1250, 2500 or 3125 Mbps");
  end
  if (FABRIC_KHZ * BITS_PER_WORD != LINE_MBPS * 1000) begin : g_bad_fab
    $error("fabric clock does not divide the line rate");
  end

  // ----------------------------------------------------------------------
  // Code functions
  // ----------------------------------------------------------------------
  function automatic logic [9:0] rev10(input logic [9:0] v);
    logic [9:0] r;
    r = '0;
    for (int i = 0; i < 10; i++) r[i] = v[9-i];
    return r;
  endfunction

  // Returns {rd_next, code group}; rd high means positive disparity
  function automatic logic [10:0] enc(input logic [7:0] b, input logic k, input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic       kk, rd6, a7, inv4, unb4;
    logic [5:0] t6;
    logic [3:0] t4;
    x    = b[4:0];
    y    = b[7:5];
    kk   = k && (x == K_X);
    t6   = kk ? K6_NEG : ENC6[x];
    rd6  = ($countones(t6) != 3) ? ~rd : rd;
    if (rd && ($countones(t6) != 3 || t6 == D7_NEG)) t6 = ~t6;
    a7   = (y == 3'h7) && (kk || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
           (rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    t4   = a7 ? A7_NEG : ENC4[y];
    unb4 = $countones(t4) != 2;
    inv4 = rd6 ? (unb4 || t4 == Y3_NEG) : (kk && !unb4 && t4 != Y3_NEG);
    if (inv4) t4 = ~t4;
    return {unb4 ? ~rd6 : rd6, rev10({t6, t4})};
  endfunction

  // Returns {valid, k, byte}
  function automatic logic [9:0] dec(input logic [9:0] cg);
    logic [9:0] s;
    logic [5:0] s6;
    logic [3:0] q;
    logic [4:0] x;
    logic [2:0] y;
    logic       kk, f6, f4, fl;
    s  = rev10(cg);
    s6 = s[9:4];
    q  = s[3:0];
    kk = (s6 == K6_NEG) || (s6 == K6_POS);
    x  = K_X;
    y  = '0;
    f6 = kk;
    f4 = 1'b0;
    for (int i = 0; i < 32; i++) begin
      fl = ($countones(ENC6[i]) != 3) || (ENC6[i] == D7_NEG);
      if (!kk && (s6 == ENC6[i] || (fl && s6 == ~ENC6[i]))) begin
        x  = 5'(i);
        f6 = 1'b1;
      end
    end
    if (s6 == K6_POS && $countones(q) == 2 && q != Y3_NEG && q != ~Y3_NEG) q = ~q;
    for (int j = 0; j < 8; j++) begin
      fl = ($countones(ENC4[j]) != 2) || (ENC4[j] == Y3_NEG);
      if (q == ENC4[j] || (fl && q == ~ENC4[j])) begin
        y  = 3'(j);
        f4 = 1'b1;
      end
    end
    if (q == A7_NEG || q == A7_POS) begin
      y  = 3'h7;
      f4 = 1'b1;
    end
    return {f6 && f4, kk, y, x};
  endfunction

  // Lowest offset in the window holding a comma, {hit, offset}
  function automatic logic [4:0] find_comma(input logic [19:0] w);
    logic [4:0] r;
    r = '0;
    for (int i = 9; i >= 0; i--) begin
      if (w[i +: 10] == COMMA_NEG || w[i +: 10] == COMMA_POS) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Transmit: queue, byte serializer, encoder
  // ----------------------------------------------------------------------
  srpcs_stream_if #(.W(TXQ_W)) txq_in ();
  srpcs_stream_if #(.W(TXQ_W)) txq_out ();

  srpcs_fifo #(.W(TXQ_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk   (clk),
    .reset (reset),
    .wr    (txq_in),
    .rd    (txq_out)
  );

  logic       phase_q, rd_q;
  logic [9:0] tx_code_q;

  // Word split into low then high byte, idle comma when queue is empty
  assign txq_in.data   = {tx_ctrl, tx_word};
  assign txq_in.valid  = tx_valid;
  assign tx_ready      = txq_in.ready;
  assign txq_out.ready = phase_q;
  wire [7:0]  tx_byte  = !txq_out.valid ? K_COMMA :
                         phase_q ? txq_out.data[15:8] : txq_out.data[7:0];
  wire        tx_k     = !txq_out.valid || (phase_q ? txq_out.data[17] : txq_out.data[16]);
  wire [10:0] tx_enc   = enc(tx_byte, tx_k, rd_q);
  assign tx_code       = tx_code_q;

  // Serializer phase and running disparity
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q   <= 1'b0;
      rd_q      <= 1'b1;
      tx_code_q <= COMMA_NEG;
    end else begin
      phase_q   <= txq_out.valid && !phase_q;
      rd_q      <= tx_enc[10];
      tx_code_q <= tx_enc[9:0];
    end
  end

  // ----------------------------------------------------------------------
  // Receive: word aligner and decoder
  // ----------------------------------------------------------------------
  typedef enum logic {SYNC_HUNT, SYNC_LOCKED} srpcs_sync_e;
  srpcs_sync_e state_q, state_d;

  logic [9:0] raw_q, cg_q;
  logic [3:0] off_q;
  wire [19:0] win   = {rx_raw, raw_q};
  wire [4:0]  hit   = find_comma(win);
  wire [9:0]  dword = dec(cg_q);
  wire        d_ok  = dword[9];
  wire        d_k   = dword[8];
  wire [7:0]  d_byte = dword[7:0];
  wire        is_comma = d_ok && (cg_q == COMMA_NEG || cg_q == COMMA_POS);

  // Alignment moves only while hunting
  always_ff @(posedge clk) begin
    if (reset) begin
      raw_q <= '0;
      cg_q  <= '0;
      off_q <= '0;
    end else begin
      raw_q <= rx_raw;
      cg_q  <= win[off_q +: 10];
      if (state_q == SYNC_HUNT && hit[4]) off_q <= hit[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // Lane synchronization machine
  // ----------------------------------------------------------------------
  logic [6:0] commas_q, commas_d;
  logic [1:0] errs_q, errs_d;
  logic [7:0] good_q, good_d;
  logic       sync_q;

  always_comb begin
    state_d  = state_q;
    commas_d = commas_q;
    errs_d   = errs_q;
    good_d   = good_q;
    unique case (state_q)
      SYNC_HUNT: begin
        errs_d = '0;
        good_d = '0;
        if (!d_ok) begin
          commas_d = '0;
        end else if (is_comma) begin
          commas_d = commas_q + 7'h1;
          if (commas_d == SYNC_COMMAS) state_d = SYNC_LOCKED;
        end
      end
      SYNC_LOCKED: begin
        commas_d = '0;
        if (!d_ok) begin
          good_d = '0;
          errs_d = errs_q + 2'h1;
          if (errs_q == ERR_LAST) state_d = SYNC_HUNT;
        end else if (errs_q != '0) begin
          good_d = good_q + 8'h1;
          if (good_d == GOOD_RUN) begin
            good_d = '0;
            errs_d = errs_q - 2'h1;
          end
        end
      end
    endcase
  end

  // Sync state and counters, lost on reset
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q  <= SYNC_HUNT;
      sync_q   <= 1'b0;
      commas_q <= '0;
      errs_q   <= '0;
      good_q   <= '0;
    end else begin
      state_q  <= state_d;
      sync_q   <= state_d == SYNC_LOCKED;
      commas_q <= commas_d;
      errs_q   <= errs_d;
      good_q   <= good_d;
    end
  end
  assign rx_sync = sync_q;

  // ----------------------------------------------------------------------
  // Skip match and byte deserializer
  // ----------------------------------------------------------------------
  logic       in_seq_q, used_q, have_q;
  logic [9:0] half_q;
  logic [19:0] word_q;
  logic       valid_q, ins_q, del_q;

  wire       is_skip = d_ok && d_k && (d_byte == K_SKIP);
  wire       can_act = sync_q && is_skip && in_seq_q && !used_q;
  wire       do_del  = can_act && rm_del_req;
  wire       do_ins  = can_act && !rm_del_req && rm_ins_req;
  wire [9:0] lane    = {!d_ok, d_k, d_byte};
  wire       one     = sync_q && !do_del && !do_ins;
  wire       two     = do_ins;

  // Compensation sequence tracking, one action per sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      in_seq_q <= 1'b0;
      used_q   <= 1'b0;
      ins_q    <= 1'b0;
      del_q    <= 1'b0;
    end else begin
      in_seq_q <= is_comma || (in_seq_q && is_skip);
      used_q   <= !is_comma && (used_q || do_del || do_ins);
      ins_q    <= do_ins;
      del_q    <= do_del;
    end
  end

  // Pairing of bytes into words, first byte in the low half
  always_ff @(posedge clk) begin
    if (reset) begin
      have_q  <= 1'b0;
      half_q  <= '0;
      word_q  <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= (one && have_q) || two;
      if (!sync_q) begin
        have_q <= 1'b0;
      end else if (two) begin
        word_q <= {lane, have_q ? half_q : lane};
        half_q <= lane;
      end else if (one) begin
        if (have_q) word_q <= {lane, half_q};
        half_q <= lane;
        have_q <= !have_q;
      end
    end
  end

  assign rx_word     = {word_q[17:10], word_q[7:0]};
  assign rx_ctrl     = {word_q[10+LANE_K], word_q[LANE_K]};
  assign rx_err      = {word_q[10+LANE_E], word_q[LANE_E]};
  assign rx_valid    = valid_q;
  assign rm_ins_done = ins_q;
  assign rm_del_done = del_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_third_err;
    state_q == SYNC_LOCKED && !d_ok && errs_q == ERR_LAST;
  endsequence
  sequence s_last_comma;
    state_q == SYNC_HUNT && is_comma && commas_q == SYNC_COMMAS - 7'h1;
  endsequence

  chk_sync_after_run: assert property (@(posedge clk) disable iff (reset)
    $rose(sync_q) |-> $past(commas_q) == SYNC_COMMAS - 7'h1 && $past(is_comma))
    else $error("sync rose without a full comma run");
  chk_run_gives_sync: assert property (@(posedge clk) disable iff (reset)
    s_last_comma |=> sync_q)
    else $error("comma run complete but no sync");
  chk_comma_forms: assert property (@(posedge clk) disable iff (reset)
    (cg_q == COMMA_NEG || cg_q == COMMA_POS) |-> is_comma && d_k && d_byte == K_COMMA)
    else $error("comma group not recognised as comma");
  chk_third_err_drop: assert property (@(posedge clk) disable iff (reset)
    s_third_err |=> !sync_q ##1 state_q == SYNC_HUNT)
    else $error("sync kept after third error");
  chk_reset_drops: assert property (@(posedge clk)
    reset |=> !sync_q && commas_q == '0)
    else $error("sync held through reset");
  chk_align_follow: assert property (@(posedge clk) disable iff (reset)
    state_q == SYNC_HUNT && hit[4] |=> off_q == $past(hit[3:0]) &&
    ($past(off_q) != $past(hit[3:0]) || cg_q == COMMA_NEG || cg_q == COMMA_POS))
    else $error("aligner did not lock onto comma");
  chk_tx_decodable: assert property (@(posedge clk) disable iff (reset)
    txq_out.valid && !phase_q |=> dec(tx_code_q) == {1'b1, $past(tx_k && tx_byte[4:0] == K_X), $past(tx_byte)})
    else $error("encoded group does not decode back");
  chk_pop_high_byte: assert property (@(posedge clk) disable iff (reset)
    txq_out.valid && !phase_q |=> phase_q && txq_out.ready)
    else $error("word popped without its second byte");
  chk_one_skip: assert property (@(posedge clk) disable iff (reset)
    (do_del || do_ins) ##1 !is_comma |-> !(do_del || do_ins) && used_q)
    else $error("second skip action in one sequence");
endmodule // srpcs_lane

// ==== srpcs_lane_tb.sv ====
// Self-checking testbench for the single-lane coding sublayer
`timescale 1ns/1ps
module srpcs_lane_tb;
  import srpcs_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic              clk = 1'b0;
  logic              reset, tx_valid, tx_ready, rx_valid, rx_sync, corrupt, stalled;
  logic              rm_ins_req, rm_del_req, rm_ins_done, rm_del_done;
  logic [WORD_W-1:0] tx_word;
  logic [WORD_W-1:0] rx_word;
  logic [CTRL_W-1:0] tx_ctrl;
  logic [CTRL_W-1:0] rx_ctrl;
  logic [CTRL_W-1:0] rx_err;
  logic [CG_W-1:0]   tx_code;
  logic [CG_W-1:0]   rx_raw;
  logic [8:0]        rxb[$];
  logic [8:0]        exp_q[$];
  int                num_errors, comparisons, ins_cnt, del_cnt, err_cnt;

  srpcs_lane #(.LINE_MBPS(3125), .FIFO_DEPTH(32)) uut (
    .clk(clk), .reset(reset), .tx_word(tx_word), .tx_ctrl(tx_ctrl), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_code(tx_code), .rx_raw(rx_raw), .rx_word(rx_word),
    .rx_ctrl(rx_ctrl), .rx_err(rx_err), .rx_valid(rx_valid), .rx_sync(rx_sync),
    .rm_ins_req(rm_ins_req), .rm_del_req(rm_del_req),
    .rm_ins_done(rm_ins_done), .rm_del_done(rm_del_done));

  srpcs_remote peer (.clk(clk), .tx_code(tx_code), .rx_raw(rx_raw), .corrupt(corrupt), .slip(4'h3));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Collect delivered bytes and done pulses where they are settled
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      rxb.push_back({rx_ctrl[0], rx_word[7:0]});
      rxb.push_back({rx_ctrl[1], rx_word[15:8]});
      err_cnt += int'(rx_err[0]) + int'(rx_err[1]);
    end
    if (rm_ins_done === 1'b1) ins_cnt++;
    if (rm_del_done === 1'b1) del_cnt++;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expd, input string what);
    comparisons++;
    if (seen !== expd) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, expd);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Offer one word, hold it until taken, and note the bytes to expect
  task automatic send(input logic [15:0] w, input logic [1:0] c);
    int t;
    @(negedge clk);
    tx_word  = w;
    tx_ctrl  = c;
    tx_valid = 1'b1;
    t = 0;
    while (tx_ready !== 1'b1 && t < 200) begin
      @(negedge clk);
      t++;
    end
    check(32'(t < 200), 1, "word accepted");
    if (t > 0) stalled = 1'b1;
    @(posedge clk);
    exp_q.push_back({c[0], w[7:0]});
    exp_q.push_back({c[1], w[15:8]});
  endtask

  task automatic idle;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask

  // One invalid group onto the lane
  task automatic hit;
    @(negedge clk);
    corrupt = 1'b1;
    @(negedge clk);
    corrupt = 1'b0;
  endtask

  task automatic wait_sync(output int n);
    n = 0;
    while (rx_sync !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Compare received bytes, idle commas left out, with those sent
  task automatic check_bytes;
    logic [8:0] got[$];
    foreach (rxb[i]) if (rxb[i] !== {1'b1, K_COMMA}) got.push_back(rxb[i]);
    check(32'(got.size()), 32'(exp_q.size()), "byte count");
    foreach (exp_q[i]) if (i < got.size()) check(32'(got[i]), 32'(exp_q[i]), "byte");
    check(32'(err_cnt), 0, "error flags");
    err_cnt = 0;
    rxb.delete();
    exp_q.delete();
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset;
    reset = 1'b1;
    cycles(2);
    check(32'(rx_sync), 0, "sync in reset");
    check(32'(tx_ready), 0, "ready in reset");
    check(32'(tx_code), 32'(COMMA_NEG), "code in reset");
    cycles(6);
    reset = 1'b0;
  endtask

  task automatic test_gain;
    int n;
    logic [9:0] a;
    cycles(40);
    hit();
    wait_sync(n);
    check(32'(n >= 127 && n <= 145), 1, "cycles to sync");
    check(32'(rxb.size()), 0, "bytes before sync");
    a = tx_code;
    cycles(1);
    check(32'(a ^ tx_code), 32'h3ff, "comma forms");
    check(32'(a === COMMA_NEG || a === COMMA_POS), 1, "comma group");
    rxb.delete();
  endtask

  task automatic test_data;
    send(16'h3412, 2'b00);
    send(16'h0000, 2'b00);
    send(16'hffff, 2'b00);
    send({8'h7c, 8'h55}, 2'b10);
    send(16'hbcbc, 2'b00);
    idle();
    cycles(30);
    check_bytes();
  endtask

  task automatic test_fill;
    stalled = 1'b0;
    for (int i = 0; i < 72; i++) send(16'(i * 16'h0301 + 16'h0102), 2'b00);
    idle();
    cycles(200);
    check(32'(stalled), 1, "queue refused");
    check_bytes();
  endtask

  task automatic test_errors;
    int n;
    err_cnt = 0;
    hit();
    cycles(300);
    hit();
    cycles(300);
    hit();
    cycles(20);
    check(32'(rx_sync), 1, "sync kept");
    check(32'(err_cnt), 3, "error bytes");
    hit();
    cycles(5);
    hit();
    cycles(5);
    hit();
    cycles(10);
    check(32'(rx_sync), 0, "sync lost");
    wait_sync(n);
    check(32'(n + 10 >= 127 && n + 10 <= 145), 1, "sync regained");
    rxb.delete();
  endtask

  // Comma plus three skips, once deleting and once inserting
  task automatic test_skip;
    int s;
    for (int m = 0; m < 2; m++) begin
      ins_cnt = 0;
      del_cnt = 0;
      rm_del_req = (m == 0);
      rm_ins_req = (m == 1);
      send({K_SKIP, K_COMMA}, 2'b11);
      send({K_SKIP, K_SKIP}, 2'b11);
      idle();
      cycles(30);
      rm_del_req = 1'b0;
      rm_ins_req = 1'b0;
      cycles(1);
      s = 0;
      foreach (rxb[i]) if (rxb[i] === {1'b1, K_SKIP}) s++;
      check(32'(del_cnt), 32'(m == 0), "deletions");
      check(32'(ins_cnt), 32'(m == 1), "insertions");
      check(32'(s), 32'(2 + 2 * m), "skips seen");
      rxb.delete();
      exp_q.delete();
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    tx_word = '0;
    tx_ctrl = '0;
    tx_valid = 1'b0;
    corrupt = 1'b0;
    rm_ins_req = 1'b0;
    rm_del_req = 1'b0;
    num_errors = 0;
    err_cnt = 0;
    comparisons = 0;
    test_reset();
    test_gain();
    test_data();
    test_fill();
    test_errors();
    test_skip();
    test_reset();
    test_done();
  end

  initial begin
    #500000;
    num_errors++;
    test_done();
  end
endmodule // srpcs_lane_tb

// ==== srpcs_pkg.sv ====
// Constants, code tables and field layouts for the serial lane coding sublayer
package srpcs_pkg;

  // ----------------------------------------------------------------------
  // Widths and field layout
  // ----------------------------------------------------------------------
  localparam int WORD_W  = 16;            // Fabric word, two bytes
  localparam int CTRL_W  = 2;             // Control flag per byte
  localparam int CG_W    = 10;            // One code group
  localparam int LANE_W  = 10;            // Received byte lane {err, k, byte}
  localparam int TXQ_W   = WORD_W + CTRL_W;
  localparam int LANE_K  = 8;             // Control flag position in a lane
  localparam int LANE_E  = 9;             // Error flag position in a lane

  // ----------------------------------------------------------------------
  // Special code groups and characters
  // ----------------------------------------------------------------------
  localparam logic [9:0] COMMA_NEG = 10'h17c;   // Comma, first bit in bit 0
  localparam logic [9:0] COMMA_POS = 10'h283;   // Its complement
  localparam logic [7:0] K_COMMA   = 8'hbc;     // Comma character
  localparam logic [7:0] K_SKIP    = 8'h1c;     // Skip character
  localparam logic [4:0] K_X       = 5'h1c;     // Only control group family
  localparam logic [5:0] K6_NEG    = 6'h0f;     // Its six-bit part
  localparam logic [5:0] K6_POS    = 6'h30;
  localparam logic [5:0] D7_NEG    = 6'h38;     // Balanced, still flips form
  localparam logic [3:0] Y3_NEG    = 4'hc;      // Balanced, still flips form
  localparam logic [3:0] A7_NEG    = 4'h7;      // Alternate x.7 form
  localparam logic [3:0] A7_POS    = 4'h8;

  // Five-to-six table, abcdei with a as MSB, negative disparity form
  localparam logic [5:0] ENC6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  // Three-to-four table, fghj with f as MSB, negative disparity form
  localparam logic [3:0] ENC4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  // ----------------------------------------------------------------------
  // Synchronization counts
  // ----------------------------------------------------------------------
  localparam logic [6:0] SYNC_COMMAS = 7'h7f;   // 127 commas to gain sync
  localparam logic [1:0] ERR_LAST    = 2'h2;    // Third error loses sync
  localparam logic [7:0] GOOD_RUN    = 8'hff;   // 255 good groups forgive one

  // ----------------------------------------------------------------------
  // Line rates and fabric clock
  // ----------------------------------------------------------------------
  localparam int RATE_LOW_MBPS  = 1250;
  localparam int RATE_MID_MBPS  = 2500;
  localparam int RATE_HIGH_MBPS = 3125;
  localparam int BITS_PER_WORD  = 20;     // Two code groups per fabric word
  localparam int CLK_PERIOD_NS  = 10;

endpackage

// ==== srpcs_remote.sv ====
// Far-end lane partner: loops code groups back with a bit offset and error injection
`timescale 1ns/1ps
module srpcs_remote (
  // Clock
  input  wire logic       clk,
  // Lane traffic
  input  wire logic [9:0] tx_code,
  output logic      [9:0] rx_raw,
  // Test controls
  input  wire logic       corrupt,
  input  wire logic [3:0] slip
);
  // ----------------------------------------------------------------------
  // Loopback lane
  // ----------------------------------------------------------------------
  logic [9:0]  cur_q  = 10'h17c;
  logic [9:0]  prev_q = 10'h283;
  logic [19:0] stream;

  // Same clock both ends, so no frequency offset to compensate
  // Single lane, no deskew needed here
  // Idle is whatever the near end sends; no random idle made here
  always_ff @(posedge clk) begin
    cur_q  <= corrupt ? 10'h000 : tx_code;   // All-zero group is never valid
    prev_q <= cur_q;
  end

  // Slice at an offset so the aligner has to hunt
  assign stream = {cur_q, prev_q};
  assign rx_raw = stream[slip +: 10];
endmodule // srpcs_remote

// ==== srpcs_stream_if.sv ====
// Valid/ready word stream between the lane and its transmit queue
`timescale 1ns/1ps
interface srpcs_stream_if #(parameter int W = 18);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
